/* hw/hsf_sof_frame_gen.sv */
// SOF frame generator with token serializer and packet deserializer
//
// Overview of operation
// - High-speed: an SOF token goes out every 125 us.
// - Full-speed: an SOF token goes out every 1 ms.
// - The SOF token is the first transmission in each period.
// - After the SOF, other transactions may fill the rest of the period.
// - While operating, SOFs keep coming whether the bus is busy or idle.
// - Without bus power, no SOF is generated.
// - With SOFs stopped, the block may flag a low-power state.
// - SOF beats every other bus access; nothing delays it.
// - Frame number increments at each period end and stays valid after.
// - Full-speed frame counter of at least 11 bits, once per ms.
// - Full-speed SOF carries the low 11 frame counter bits.
// - High-speed microframe counter of at least 14 bits, per 125 us.
// - High-speed SOF carries counter bits 3 to 13.
// - Software reads the frame number current when the read completes.
// - No transmission starts or continues inside the EOF interval.
// - At EOF start, pending work scheduled for the ending period retires.
// - A transaction still running when EOF arrives is aborted.
// - Downstream resume raises a resume notice to the host.
// - The block may start a resume by driving resume itself.
// - Bus can be suspended; wakeup events from the bus are answered.
// - Outgoing packets get PIDs; incoming PIDs are stripped and checked.
// - Host data is serialized out and received bits deserialized.
// - Suspend command stops all traffic, SOFs included.
`timescale 1ns/1ps
module hsf_sof_frame_gen #(
    parameter int unsigned FS_PERIOD_CYC = hsf_pkg::FS_PERIOD_CYC,
    parameter int unsigned HS_PERIOD_CYC = hsf_pkg::HS_PERIOD_CYC,
    parameter int unsigned EOF_CYC = hsf_pkg::EOF_CYC_DEF,
    parameter int unsigned RESUME_CYC = hsf_pkg::RESUME_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run_en,
    input wire logic hs_mode,
    input wire logic port_power,
    input wire logic suspend_req,
    input wire logic wake_en,
    input wire logic host_resume_req,
    input wire logic bus_resume,
    input wire logic txn_valid,
    input wire hsf_pkg::hsf_txn_type txn_req,
    output logic txn_ready,
    output logic txn_done,
    output logic txn_retired,
    output logic txn_aborted,
    output logic tx_bit,
    output logic tx_en,
    output logic sof_pulse,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic rx_eop,
    output hsf_pkg::hsf_rx_type rx_word,
    output logic rx_word_valid,
    output logic rx_pid_err,
    input wire logic fn_rd_req,
    output logic fn_rd_ack,
    output logic [hsf_pkg::FRAME_W-1:0] fn_rd_data,
    output logic resume_notice,
    output logic resume_drive,
    output logic suspended,
    output logic low_power
);
    import hsf_pkg::*;

    // ========================================
    // Elaboration checks
    // The EOF window plus a full SOF and one transaction must fit inside the short period
    if (EOF_CYC + SOF_BITS + TXN_BITS >= HS_PERIOD_CYC
        || FS_PERIOD_CYC >= (1 << CNT_W)
        || RESUME_CYC >= (1 << CNT_W) || RESUME_CYC == 0) begin : g_bad
        $error("hsf_sof_frame_gen: unsupported timing parameters");
    end

    localparam logic [CNT_W-1:0] FS_LAST = CNT_W'(FS_PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] HS_LAST = CNT_W'(HS_PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] FS_EOF = CNT_W'(FS_PERIOD_CYC - EOF_CYC);
    localparam logic [CNT_W-1:0] HS_EOF = CNT_W'(HS_PERIOD_CYC - EOF_CYC);
    localparam logic [CNT_W-1:0] RES_LAST = CNT_W'(RESUME_CYC - 1);
    localparam logic [CNT_W-1:0] TXN_LEN = CNT_W'(TXN_BITS);
    localparam logic [BITS_W-1:0] SOF_N = BITS_W'(SOF_BITS);
    localparam logic [BITS_W-1:0] TXN_N = BITS_W'(TXN_BITS);
    localparam logic [BITS_W-1:0] BIT_ONE = 5'h01;
    localparam logic [BITS_W-1:0] RX_LAST = BITS_W'(TXN_BITS - 1);

    // ========================================
    // Field helpers
    function automatic logic [CRC_W-1:0] crc5(input logic [FIELD_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 0; i < FIELD_W; i++) begin
            fb = d[i] ^ c[CRC_W-1];
            c = {c[CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        c = ~c;
        // Residue goes out high bit first on an LSB-first wire
        for (int i = 0; i < CRC_W; i++) begin
            crc5[i] = c[CRC_W-1-i];
        end
    endfunction

    function automatic logic [2*PID_W-1:0] pid_byte(input logic [3:0] p);
        pid_byte = {~p, p};
    endfunction

    // ========================================
    // State
    hsf_state_type state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] res_cnt_ff, nxt_res_cnt;
    logic [FRAME_W-1:0] frame_ff, nxt_frame;
    logic [SH_W-1:0] sh_ff, nxt_sh;
    logic [BITS_W-1:0] bits_ff, nxt_bits;
    logic pend_ff, nxt_pend;
    hsf_txn_type pend_req_ff, nxt_pend_req;
    logic sof_ff, nxt_sof;
    logic done_ff, nxt_done;
    logic retire_ff, nxt_retire;
    logic abort_ff, nxt_abort;
    logic notice_ff, nxt_notice;
    logic [TXN_BITS-1:0] rx_sh_ff, nxt_rx_sh;
    logic [BITS_W-1:0] rx_cnt_ff, nxt_rx_cnt;
    hsf_rx_type rx_word_ff, nxt_rx_word;
    logic rx_vld_ff, nxt_rx_vld;
    logic rx_err_ff, nxt_rx_err;

    logic [CNT_W-1:0] last_cnt;
    logic [CNT_W-1:0] eof_cnt;
    logic eof_on;
    logic room;
    logic [FRAME_W-1:0] frame_inc;
    logic [FIELD_W-1:0] sof_field;
    logic [TXN_BITS-1:0] rx_tmp;

    always_comb begin
        last_cnt = hs_mode ? HS_LAST : FS_LAST;
        eof_cnt = hs_mode ? HS_EOF : FS_EOF;
        eof_on = (cnt_ff >= eof_cnt);
        // A transaction may only start if it ends before EOF
        room = ((cnt_ff + TXN_LEN) < eof_cnt);
        frame_inc = frame_ff + 14'h0001;
        sof_field = hs_mode ?
            frame_inc[HS_FIELD_LSB +: FIELD_W] :
            frame_inc[FS_FIELD_LSB +: FIELD_W];
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 16'h0001;
        nxt_res_cnt = res_cnt_ff;
        nxt_frame = frame_ff;
        nxt_sh = sh_ff;
        nxt_bits = bits_ff;
        nxt_pend = pend_ff;
        nxt_pend_req = pend_req_ff;
        nxt_sof = 1'b0;
        nxt_done = 1'b0;
        nxt_retire = 1'b0;
        nxt_abort = 1'b0;
        nxt_notice = 1'b0;
        if (txn_valid && !pend_ff) begin
            nxt_pend = 1'b1;
            nxt_pend_req = txn_req;
        end
        unique case (state_ff)
            ST_OFF: begin
                nxt_cnt = CNT_RST;
                if (run_en && port_power && !suspend_req) begin
                    nxt_state = ST_EOF;
                    nxt_cnt = last_cnt;
                end
            end
            ST_SOF, ST_TXN: begin
                nxt_sh = {1'b0, sh_ff[SH_W-1:1]};
                nxt_bits = bits_ff - BIT_ONE;
                if (state_ff == ST_TXN && eof_on) begin
                    nxt_state = ST_EOF;
                    nxt_abort = 1'b1;
                    nxt_pend = 1'b0;
                end else if (bits_ff == BIT_ONE) begin
                    nxt_state = ST_RUN;
                    if (state_ff == ST_TXN) begin
                        nxt_done = 1'b1;
                        nxt_pend = 1'b0;
                    end
                end
            end
            ST_RUN: begin
                if (!run_en || !port_power) begin
                    nxt_state = ST_OFF;
                    nxt_pend = 1'b0;
                end else if (suspend_req) begin
                    nxt_state = ST_SUSP;
                    nxt_pend = 1'b0;
                end else if (eof_on) begin
                    nxt_state = ST_EOF;
                    if (pend_ff
                        && pend_req_ff.tag == frame_ff[TAG_W-1:0]) begin
                        nxt_pend = 1'b0;
                        nxt_retire = 1'b1;
                    end
                end else if (pend_ff && room) begin
                    nxt_state = ST_TXN;
                    nxt_sh = SH_W'({pend_req_ff.data,
                        pid_byte(pend_req_ff.pid)});
                    nxt_bits = TXN_N;
                end
            end
            ST_EOF: begin
                // Bus stays quiet until the period boundary
                if (cnt_ff == last_cnt) begin
                    if (!run_en || !port_power) begin
                        nxt_state = ST_OFF;
                    end else if (suspend_req) begin
                        nxt_state = ST_SUSP;
                    end else begin
                        // SOF leaves before any pending transaction
                        nxt_state = ST_SOF;
                        nxt_cnt = CNT_RST;
                        nxt_frame = frame_inc;
                        nxt_sof = 1'b1;
                        nxt_sh = {crc5(sof_field), sof_field,
                            pid_byte(PID_SOF)};
                        nxt_bits = SOF_N;
                    end
                end
            end
            ST_SUSP: begin
                nxt_cnt = CNT_RST;
                nxt_res_cnt = CNT_RST;
                if (!port_power) begin
                    nxt_state = ST_OFF;
                end else if (bus_resume && wake_en) begin
                    nxt_state = ST_RESUME;
                    nxt_notice = 1'b1;
                end else if (host_resume_req) begin
                    nxt_state = ST_RESUME;
                end
            end
            ST_RESUME: begin
                nxt_res_cnt = res_cnt_ff + 16'h0001;
                nxt_cnt = CNT_RST;
                if (res_cnt_ff == RES_LAST) begin
                    nxt_state = ST_EOF;
                    nxt_cnt = last_cnt;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
        // Deserializer, PID stripped and checked
        rx_tmp = {rx_bit, rx_sh_ff[TXN_BITS-1:1]};
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_word = rx_word_ff;
        nxt_rx_vld = 1'b0;
        nxt_rx_err = 1'b0;
        if (rx_eop) begin
            nxt_rx_cnt = '0;
        end else if (rx_valid) begin
            nxt_rx_sh = rx_tmp;
            nxt_rx_cnt = rx_cnt_ff + BIT_ONE;
            if (rx_cnt_ff == RX_LAST) begin
                nxt_rx_cnt = '0;
                if (rx_tmp[2*PID_W-1:PID_W] == ~rx_tmp[PID_W-1:0]) begin
                    nxt_rx_word.pid = rx_tmp[PID_W-1:0];
                    nxt_rx_word.data = rx_tmp[TXN_BITS-1:2*PID_W];
                    nxt_rx_vld = 1'b1;
                end else begin
                    nxt_rx_err = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_ff <= ST_OFF;
            cnt_ff <= CNT_RST;
            res_cnt_ff <= CNT_RST;
            frame_ff <= FRAME_RST;
            sh_ff <= '0;
            bits_ff <= '0;
            pend_ff <= 1'b0;
            pend_req_ff <= '0;
            sof_ff <= 1'b0;
            done_ff <= 1'b0;
            retire_ff <= 1'b0;
            abort_ff <= 1'b0;
            notice_ff <= 1'b0;
            rx_sh_ff <= '0;
            rx_cnt_ff <= '0;
            rx_word_ff <= '0;
            rx_vld_ff <= 1'b0;
            rx_err_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            res_cnt_ff <= nxt_res_cnt;
            frame_ff <= nxt_frame;
            sh_ff <= nxt_sh;
            bits_ff <= nxt_bits;
            pend_ff <= nxt_pend;
            pend_req_ff <= nxt_pend_req;
            sof_ff <= nxt_sof;
            done_ff <= nxt_done;
            retire_ff <= nxt_retire;
            abort_ff <= nxt_abort;
            notice_ff <= nxt_notice;
            rx_sh_ff <= nxt_rx_sh;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_word_ff <= nxt_rx_word;
            rx_vld_ff <= nxt_rx_vld;
            rx_err_ff <= nxt_rx_err;
        end
    end

    // ========================================
    // Outputs
    assign txn_ready = !pend_ff;
    assign txn_done = done_ff;
    assign txn_retired = retire_ff;
    assign txn_aborted = abort_ff;
    assign tx_bit = sh_ff[0];
    // Transmit only from SOF and TXN states, never in EOF
    assign tx_en = (state_ff == ST_SOF) || (state_ff == ST_TXN);
    assign sof_pulse = sof_ff;
    assign rx_word = rx_word_ff;
    assign rx_word_valid = rx_vld_ff;
    assign rx_pid_err = rx_err_ff;
    assign fn_rd_ack = fn_rd_req;
    assign fn_rd_data = frame_ff;
    assign resume_notice = notice_ff;
    assign resume_drive = (state_ff == ST_RESUME);
    assign suspended = (state_ff == ST_SUSP);
    assign low_power = (state_ff == ST_SUSP) || (state_ff == ST_OFF);

endmodule // hsf_sof_frame_gen

/* hw/hsf_pkg.sv */
// Package of constants and carrier types for the SOF frame generator
package hsf_pkg;
    // ========================================
    // Timing
    localparam int unsigned CLK_PERIOD_PS = 25_000;
    localparam int unsigned FS_PERIOD_US = 1_000;
    localparam int unsigned HS_PERIOD_US = 125;
    // Both periods round down to whole cycles
    localparam int unsigned FS_PERIOD_CYC = FS_PERIOD_US * 1_000_000
        / CLK_PERIOD_PS;
    localparam int unsigned HS_PERIOD_CYC = HS_PERIOD_US * 1_000_000
        / CLK_PERIOD_PS;
    localparam int unsigned EOF_CYC_DEF = 64;
    localparam int unsigned RESUME_CYC_DEF = 800;
    localparam int CNT_W = 16;
    // ========================================
    // Frame number and token fields
    localparam int FRAME_W = 14;
    localparam int FIELD_W = 11;
    localparam int FS_FIELD_LSB = 0;
    localparam int HS_FIELD_LSB = 3;
    localparam int CRC_W = 5;
    localparam logic [4:0] CRC_INIT = 5'h1f;
    localparam logic [4:0] CRC_POLY = 5'h05;
    localparam logic [3:0] PID_SOF = 4'h5;
    localparam int PID_W = 4;
    localparam int BYTE_W = 8;
    localparam int TAG_W = 3;
    localparam int SOF_BITS = 2 * PID_W + FIELD_W + CRC_W;
    localparam int TXN_BITS = 2 * PID_W + BYTE_W;
    localparam int SH_W = SOF_BITS;
    localparam int BITS_W = 5;
    localparam logic [FRAME_W-1:0] FRAME_RST = 14'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    // ========================================
    // Carriers
    typedef struct packed {
        logic [PID_W-1:0] pid;
        logic [BYTE_W-1:0] data;
        logic [TAG_W-1:0] tag;
    } hsf_txn_type;
    typedef struct packed {
        logic [PID_W-1:0] pid;
        logic [BYTE_W-1:0] data;
    } hsf_rx_type;
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_SOF = 7'h02,
        ST_RUN = 7'h04,
        ST_TXN = 7'h08,
        ST_EOF = 7'h10,
        ST_SUSP = 7'h20,
        ST_RESUME = 7'h40
    } hsf_state_type;
endpackage

/* testbench/hsf_sof_frame_gen_monitor.sv */
// Port-level checker of the SOF frame generator
`timescale 1ns/1ps
module hsf_sof_frame_gen_monitor
    import hsf_pkg::*;
#(
    parameter int unsigned FS_PERIOD_CYC = 400,
    parameter int unsigned HS_PERIOD_CYC = 200
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hs_mode,
    input wire logic port_power,
    input wire logic wake_en,
    input wire logic bus_resume,
    input wire logic fn_rd_req,
    input wire logic fn_rd_ack,
    input wire logic [hsf_pkg::FRAME_W-1:0] fn_rd_data,
    input wire logic sof_pulse,
    input wire logic tx_en,
    input wire logic txn_done,
    input wire logic txn_retired,
    input wire logic txn_aborted,
    input wire logic rx_word_valid,
    input wire logic rx_pid_err,
    input wire logic resume_notice,
    input wire logic resume_drive,
    input wire logic suspended,
    input wire logic low_power
);
    int gap_ff;
    int nxt_gap;
    logic gok_ff;
    logic nxt_gok;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // ========================================
    // Period tracking, dropped whenever SOFs pause
    always_comb begin
        nxt_gap = sof_pulse ? 1 : gap_ff + 1;
        nxt_gok = sof_pulse | (gok_ff & ~low_power & ~resume_drive);
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gap_ff <= 0;
            gok_ff <= 1'b0;
        end else begin
            gap_ff <= nxt_gap;
            gok_ff <= nxt_gok;
        end
    end
    // ========================================
    // Assertions
    a_sof_period: assert property (
        sof_pulse && gok_ff |-> gap_ff ==
        (hs_mode ? int'(HS_PERIOD_CYC) : int'(FS_PERIOD_CYC)))
        else $error("sof period wrong");
    a_sof_first: assert property (sof_pulse |-> tx_en)
        else $error("sof pulse without transmit");
    a_sof_length: assert property (sof_pulse |-> ##23 tx_en ##1 !tx_en)
        else $error("sof token length wrong");
    a_frame_step: assert property (sof_pulse |->
        fn_rd_data == $past(fn_rd_data) + 14'h0001)
        else $error("frame number did not step");
    a_frame_hold: assert property (!sof_pulse |-> $stable(fn_rd_data))
        else $error("frame number moved between sofs");
    a_read_ack: assert property (fn_rd_req |-> fn_rd_ack)
        else $error("frame read not answered");
    a_unpowered_quiet: assert property (!port_power ##1 !port_power
        |-> !tx_en && !sof_pulse)
        else $error("transmit without bus power");
    a_suspend_quiet: assert property (
        suspended |-> low_power && !tx_en)
        else $error("traffic while suspended");
    a_one_outcome: assert property (
        $onehot0({txn_done, txn_retired, txn_aborted}))
        else $error("two outcomes for one transaction");
    a_rx_exclusive: assert property (!(rx_word_valid && rx_pid_err))
        else $error("rx word both good and bad");
    a_resume_cause: assert property (resume_notice |->
        $past(bus_resume) && $past(wake_en) && $past(suspended))
        else $error("resume notice without cause");
endmodule // hsf_sof_frame_gen_monitor

bind hsf_sof_frame_gen hsf_sof_frame_gen_monitor #(
    .FS_PERIOD_CYC(FS_PERIOD_CYC), .HS_PERIOD_CYC(HS_PERIOD_CYC)) u_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .hs_mode(hs_mode),
    .port_power(port_power), .wake_en(wake_en), .bus_resume(bus_resume),
    .fn_rd_req(fn_rd_req), .fn_rd_ack(fn_rd_ack), .fn_rd_data(fn_rd_data),
    .sof_pulse(sof_pulse), .tx_en(tx_en), .txn_done(txn_done),
    .txn_retired(txn_retired), .txn_aborted(txn_aborted),
    .rx_word_valid(rx_word_valid), .rx_pid_err(rx_pid_err),
    .resume_notice(resume_notice), .resume_drive(resume_drive),
    .suspended(suspended), .low_power(low_power));

/* testbench/hsf_far_end.sv */
// Downstream model: captures bus words, sends packets upstream
`timescale 1ns/1ps
module hsf_far_end (
    input wire logic ref_clk,
    input wire logic tx_en,
    input wire logic tx_bit,
    output logic rx_valid,
    output logic rx_bit,
    output logic rx_eop,
    output logic [23:0] cap
);
    logic [23:0] sh = 24'h000000;
    int n = 0;
    initial begin
        rx_valid = 1'b0;
        rx_bit = 1'b0;
        rx_eop = 1'b0;
        cap = 24'h000000;
    end
    // ========================================
    // Capture LSB first, word kept right-aligned
    always @(posedge ref_clk) begin
        if (tx_en === 1'b1) begin
            sh <= {tx_bit, sh[23:1]};
            n <= n + 1;
        end else if (n != 0) begin
            cap <= sh >> (24 - n);
            n <= 0;
        end
    end
    // ========================================
    // Send; line shows inverse once released
    task automatic send(input logic [15:0] w);
        @(negedge ref_clk) rx_eop = 1'b1;
        @(negedge ref_clk) rx_eop = 1'b0;
        for (int i = 0; i < 16; i++) begin
            rx_valid = 1'b1;
            rx_bit = w[i];
            @(negedge ref_clk);
        end
        rx_valid = 1'b0;
        rx_bit = ~rx_bit;
    endtask
endmodule // hsf_far_end

/* testbench/test_hsf_sof_frame_gen.sv */
// Bench: drives the SOF frame generator and checks it against a model
`timescale 1ns/1ps
module test_hsf_sof_frame_gen;
    import hsf_pkg::*;
    localparam int unsigned FSP = 400;
    localparam int unsigned HSP = 200;
    localparam int unsigned EOFC = 32;
    logic ref_clk = 1'b0, rst_b = 1'b0, run_en = 1'b0, hs_mode = 1'b0;
    logic port_power = 1'b1, suspend_req = 1'b0, wake_en = 1'b0;
    logic host_resume_req = 1'b0, bus_resume = 1'b0, txn_valid = 1'b0;
    logic fn_rd_req = 1'b0;
    hsf_txn_type txn_req = '0;
    hsf_rx_type rx_word;
    logic txn_ready, txn_done, txn_retired, txn_aborted, tx_bit, tx_en;
    logic sof_pulse, rx_valid, rx_bit, rx_eop, rx_word_valid, rx_pid_err;
    logic fn_rd_ack, resume_notice, resume_drive, suspended, low_power;
    logic [FRAME_W-1:0] fn_rd_data;
    logic [23:0] cap;
    // Expected transaction words, oldest first
    logic [23:0] exp_q[$];
    logic [31:0] rnd = 32'h0000603d;
    int fails = 0, total_checks = 0, cyc = 0, frm = 0, sofs = 0, s0;
    hsf_sof_frame_gen #(.FS_PERIOD_CYC(FSP), .HS_PERIOD_CYC(HSP),
        .EOF_CYC(EOFC), .RESUME_CYC(8)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .run_en(run_en),
        .hs_mode(hs_mode), .port_power(port_power),
        .suspend_req(suspend_req), .wake_en(wake_en),
        .host_resume_req(host_resume_req), .bus_resume(bus_resume),
        .txn_valid(txn_valid), .txn_req(txn_req), .txn_ready(txn_ready),
        .txn_done(txn_done), .txn_retired(txn_retired),
        .txn_aborted(txn_aborted), .tx_bit(tx_bit), .tx_en(tx_en),
        .sof_pulse(sof_pulse), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .rx_eop(rx_eop), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .rx_pid_err(rx_pid_err), .fn_rd_req(fn_rd_req),
        .fn_rd_ack(fn_rd_ack), .fn_rd_data(fn_rd_data),
        .resume_notice(resume_notice), .resume_drive(resume_drive),
        .suspended(suspended), .low_power(low_power));
    hsf_far_end fe (.ref_clk(ref_clk), .tx_en(tx_en), .tx_bit(tx_bit),
        .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_eop(rx_eop), .cap(cap));
    // ========================================
    // Clock, cycle ceiling, SOF count
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (sof_pulse === 1'b1) sofs <= sofs + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    // ========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [23:0] tok(input logic [10:0] f);
        logic [4:0] c;
        logic [23:0] t;
        c = CRC_INIT;
        for (int i = 0; i < 11; i++)
            c = {c[3:0], 1'b0} ^ (f[i] ^ c[4] ? CRC_POLY : 5'h00);
        t = {5'h00, f, ~PID_SOF, PID_SOF};
        for (int i = 0; i < 5; i++) t[19+i] = ~c[4-i];
        return t;
    endfunction
    task automatic chk_w(input logic [23:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, exp);
        chk_w({23'h000000, got}, {23'h000000, exp});
    endtask
    task automatic rst_chk();
        chk_w(24'(fn_rd_data), 24'h000000);
        chk_b(txn_ready & low_power & ~tx_en, 1'b1);
    endtask
    // Waits for the next SOF, reads the frame, checks the token
    task automatic sof_chk();
        int k;
        for (k = 0; k < 900 && sof_pulse !== 1'b1; k++) @(negedge ref_clk);
        frm++;
        chk_b(sof_pulse, 1'b1);
        fn_rd_req = 1'b1;
        #1 chk_w(24'(fn_rd_data), 24'(frm));
        chk_b(fn_rd_ack, 1'b1);
        repeat (25) @(negedge ref_clk) fn_rd_req = 1'b0;
        chk_w(cap, tok(hs_mode ? frm[13:3] : frm[10:0]));
    endtask
    // Late requests land past the start limit and wait for EOF
    task automatic txn(input logic [2:0] tg, input logic late, ok);
        int k;
        rnd = xs(rnd);
        if (late) repeat (FSP - EOFC - 36) @(negedge ref_clk);
        txn_req = '{pid: rnd[3:0], data: rnd[11:4], tag: tg};
        if (ok) exp_q.push_back({8'h00, rnd[11:4], ~rnd[3:0], rnd[3:0]});
        txn_valid = 1'b1;
        for (k = 0; k < 99 && txn_ready !== 1'b1; k++) @(negedge ref_clk);
        @(negedge ref_clk) txn_valid = 1'b0;
        for (k = 0; k < 900
            && (txn_done | txn_retired | txn_aborted) !== 1'b1; k++)
            @(negedge ref_clk);
        chk_b(txn_done, ok);
        chk_b(txn_retired, ~ok);
        chk_b(txn_aborted, 1'b0);
        @(negedge ref_clk);
        if (ok) chk_w(cap, exp_q.pop_front());
    endtask
    task automatic rx(input logic bad);
        int k;
        rnd = xs(rnd);
        fe.send({rnd[15:8], rnd[3:0] ^ {4{~bad}}, rnd[3:0]});
        for (k = 0; k < 9 && (rx_word_valid | rx_pid_err) !== 1'b1; k++)
            @(negedge ref_clk);
        chk_b(rx_word_valid, ~bad);
        chk_b(rx_pid_err, bad);
        if (!bad) chk_w(24'(rx_word), 24'({rnd[3:0], rnd[15:8]}));
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_chk();
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_b(tx_en | sof_pulse, 1'b0);
        run_en = 1'b1;
        sof_chk();
        txn(frm[2:0] + 3'h1, 1'b0, 1'b1);
        sof_chk();
        txn(frm[2:0], 1'b1, 1'b0);
        sof_chk();
        txn(frm[2:0] + 3'h1, 1'b1, 1'b1);
        frm++;
        sof_chk();
        rx(1'b0);
        rx(1'b1);
        suspend_req = 1'b1;
        s0 = sofs;
        repeat (3 * FSP) @(negedge ref_clk);
        chk_b(suspended, 1'b1);
        chk_w(24'(sofs - s0), 24'h000000);
        suspend_req = 1'b0;
        // Bus wakeup is ignored until software enables it
        bus_resume = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_b(suspended, 1'b1);
        wake_en = 1'b1;
        for (int k = 0; k < 9 && resume_notice !== 1'b1; k++)
            @(negedge ref_clk);
        chk_b(resume_notice, 1'b1);
        bus_resume = 1'b0;
        sof_chk();
        suspend_req = 1'b1;
        repeat (FSP) @(negedge ref_clk);
        suspend_req = 1'b0;
        host_resume_req = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_b(resume_drive, 1'b1);
        host_resume_req = 1'b0;
        sof_chk();
        port_power = 1'b0;
        s0 = sofs;
        repeat (2 * FSP) @(negedge ref_clk);
        chk_b(low_power, 1'b1);
        chk_w(24'(sofs - s0), 24'h000000);
        port_power = 1'b1;
        sof_chk();
        run_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        hs_mode = 1'b1;
        run_en = 1'b1;
        repeat (10) sof_chk();
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_chk();
        frm = 0;
        rst_b = 1'b1;
        sof_chk();
        wrap_up();
    end
endmodule // test_hsf_sof_frame_gen
